// file: shared/brst_consts.svh
// Purpose: constants for the brown-out reset sequencer
// Assumes: 100 MHz core clock
// Notes:   offsets are word indices on the plain register port
`ifndef BRST_CONSTS_SVH
`define BRST_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BRST_OFS_CAUSE       2'h0
`define BRST_OFS_STATE       2'h1
`define BRST_OFS_QUAL        2'h2

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define BRST_CAUSE_BOR_BIT   0
`define BRST_CAUSE_POR_BIT   1
`define BRST_QUAL_RESET      8'h10
`define BRST_INIT_VALUE      8'hff

// ----------------------------------------------------------------
// program counter values
// ----------------------------------------------------------------
`define BRST_PC_RESET        13'h0000
`define BRST_PC_IRQ_VEC      13'h0004

// ----------------------------------------------------------------
// status register loads: mask marks bits that change
// ----------------------------------------------------------------
`define BRST_ST_POR_MASK     8'hf8
`define BRST_ST_POR_VAL      8'h18
`define BRST_ST_MRUN_MASK    8'he0
`define BRST_ST_MRUN_VAL     8'h00
`define BRST_ST_MSLP_MASK    8'hf8
`define BRST_ST_MSLP_VAL     8'h10
`define BRST_ST_WDT_MASK     8'hf8
`define BRST_ST_WDT_VAL      8'h08
`define BRST_ST_WWAKE_MASK   8'h18
`define BRST_ST_WWAKE_VAL    8'h00
`define BRST_ST_IWAKE_MASK   8'h18
`define BRST_ST_IWAKE_VAL    8'h10

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BRST_CLK_KHZ         100000
`define BRST_POWERUP_TIMER_MS         72
`define BRST_POWERUP_TIMER_CYCLES     (`BRST_POWERUP_TIMER_MS * `BRST_CLK_KHZ)
`define BRST_OST_TICKS       11'd1024

`endif

// file: shared/brst_pkg.sv
// Purpose: types for the brown-out reset sequencer
// Assumes: constants live in brst_consts.svh
// Notes:   none
package brst_pkg;

    // ------------------------------------------------------------
    // oscillator modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BRST_OSC_LP = 2'h0,
        BRST_OSC_XT = 2'h1,
        BRST_OSC_HS = 2'h2,
        BRST_OSC_RC = 2'h3
    } brst_osc_t;

    // ------------------------------------------------------------
    // configuration bits
    // ------------------------------------------------------------
    typedef struct packed {
        logic      brownout_enable;
        logic      brownout_level_select;
        logic      powerup_timer_enable_n;
        brst_osc_t osc_select;
    } brst_cfg_t;

    // ------------------------------------------------------------
    // sequencer states, gray along power-up path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BRST_S_POR   = 3'h0,
        BRST_S_HOLD  = 3'h1,
        BRST_S_POWERUP_TIMER  = 3'h3,
        BRST_S_OST   = 3'h2,
        BRST_S_MCLRW = 3'h6,
        BRST_S_RUN   = 3'h7,
        BRST_S_SLEEP = 3'h5,
        BRST_S_WAKE  = 3'h4
    } brst_state_t;

    // ------------------------------------------------------------
    // last reset or wake cause
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BRST_C_POR   = 3'h0,
        BRST_C_BOR   = 3'h1,
        BRST_C_MRUN  = 3'h2,
        BRST_C_MSLP  = 3'h3,
        BRST_C_WDT   = 3'h4,
        BRST_C_WWAKE = 3'h5,
        BRST_C_IWAKE = 3'h6
    } brst_cause_t;

    // ------------------------------------------------------------
    // load to the core when it is released
    // ------------------------------------------------------------
    typedef struct packed {
        logic        load;
        logic        reg_init;
        logic [12:0] pc;
        logic [7:0]  status_mask;
        logic [7:0]  status_value;
        logic [7:0]  init_value;
    } brst_core_load_t;

endpackage : brst_pkg

// file: core/brst_seq.sv
// Purpose: brown-out reset, power-up and start-up sequencing
// Assumes: all inputs but SUPPLY_LOW_4V0 and SUPPLY_LOW_2V5 synchronous to CLK, OSC_TICK one pulse per osc cycle
// Notes:   RST is the on-chip power-on pulse
`timescale 1ns/100ps
`default_nettype none
`include "brst_consts.svh"

// Function
// RL1 - brownout_enable turns brown-out detection on/off
// RL2 - level select: 1 is 4.0V, 0 is 2.5V
// RL3 - reset only after dip outlasts minimum duration
// RL4 - hold reset while supply below threshold
// RL5 - add 72 ms delay when timer enabled
// RL6 - dip during delay restarts full delay
// RL7 - power-on pulse, then delay, then start-up count
// RL8 - RC mode, no delay: no time-out
// RL9 - timers ignore master clear; late release immediate
// RL10 - cause bit 0 set on power-on, cleared by brown-out
// RL11 - bit 0 undefined when detection disabled
// RL12 - cause bit 1 cleared only by power-on
// RL13 - time-out lengths per oscillator mode and event
// RL14 - power-on sets timeout/powerdown flags, clears power-on bit
// RL15 - flag codes for each reset and wake
// RL16 - resets load PC 000h; wakes PC+1 or 0004h; in RC mode a wake loads per the cause held before the wake
// RL17 - status register value per reset kind
// RL18 - cause register value per reset kind
// RL19 - resets load initial register values; wakes do not; in RC mode a wake loads per the cause held before the wake
// RL20 - start-up timer counts 1024 oscillator cycles
// RL21 - start-up count only crystal modes, power-on/wake
// RL22 - osc_select encodings 11 RC, 10 HS, 01 XT, 00 LP
// RL23 - power-up delay enable is active low
// RL24 - synchronise supply-low, qualify with programmable counter
module brst_seq #(
    parameter int unsigned POWERUP_TIMER_CYCLES = `BRST_POWERUP_TIMER_CYCLES
) (
    // clock, reset, enable
    input  wire logic                      CLK,
    input  wire logic                      RST,
    input  wire logic                      CE,
    // configuration and supply monitors
    input  wire brst_pkg::brst_cfg_t       CFG,
    input  wire logic                      SUPPLY_LOW_4V0,
    input  wire logic                      SUPPLY_LOW_2V5,
    input  wire logic                      OSC_TICK,
    // reset and wake sources
    input  wire logic                      MASTER_CLEAR_N,
    input  wire logic                      WATCHDOG_TIMEOUT,
    input  wire logic                      SLEEP_ENTER,
    input  wire logic                      IRQ_WAKE,
    input  wire logic                      GLOBAL_IRQ_ENABLE,
    input  wire logic [12:0]               PC_NOW,
    // register port
    input  wire logic [1:0]                REG_ADDR,
    input  wire logic [7:0]                REG_WDATA,
    input  wire logic                      REG_WR,
    input  wire logic                      REG_RD,
    output var  logic [7:0]                REG_RDATA,
    // core control
    output var  logic                      CORE_RESET,
    output var  logic                      CORE_RUN,
    output var  logic                      TIMEOUT_FLAG_N,
    output var  logic                      POWERDOWN_FLAG_N,
    output var  brst_pkg::brst_core_load_t CORE_LOAD
);
    import brst_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam logic [22:0] POWERUP_TIMER_LAST = 23'(POWERUP_TIMER_CYCLES - 1);

    logic [1:0]  low_meta_r;
    logic [1:0]  low_sync_r;
    logic        supply_low;
    logic [7:0]  qual_cnt_r;
    logic [7:0]  qual_len_r;
    logic        bor_event;
    brst_state_t state_r;
    brst_state_t state_nxt;
    brst_cause_t cause_r;
    brst_cause_t cause_nxt;
    logic [22:0] powerup_timer_cnt_r;
    logic [10:0] ost_cnt_r;
    logic        crystal;
    logic        powerup_timer_on;
    logic        ost_done;
    logic        powerup_timer_done;
    logic        bor_bit_r;
    logic        por_bit_r;
    logic        to_n_r;
    logic        pd_n_r;
    logic        wake_irq_r;
    logic [15:0] st_load;

    // RL22 crystal mode decode
    assign crystal   = (CFG.osc_select != BRST_OSC_RC);
    // RL23 active-low delay enable
    assign powerup_timer_on   = ~CFG.powerup_timer_enable_n;
    assign powerup_timer_done = (powerup_timer_cnt_r == POWERUP_TIMER_LAST);
    // RL20 start-up count end
    assign ost_done  = (ost_cnt_r == `BRST_OST_TICKS);

    // ------------------------------------------------------------
    // supply monitor synchronisers
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            // RL24 two-flop synchroniser
            always_ff @(posedge CLK) begin
                if (RST) begin
                    low_meta_r[gi] <= 1'b0;
                    low_sync_r[gi] <= 1'b0;
                end else if (CE) begin
                    low_meta_r[gi] <= (gi == 0) ? SUPPLY_LOW_2V5 : SUPPLY_LOW_4V0;
                    low_sync_r[gi] <= low_meta_r[gi];
                end
            end
        end
    endgenerate

    // RL2 threshold select; RL1 disabled means never low
    assign supply_low = CFG.brownout_enable &
                        (CFG.brownout_level_select ? low_sync_r[1] : low_sync_r[0]);

    // ------------------------------------------------------------
    // brown-out qualification
    // ------------------------------------------------------------
    // RL3 dip must outlast qual_len_r cycles
    always_ff @(posedge CLK) begin
        if (RST) begin
            qual_cnt_r <= 8'h00;
        end else if (CE) begin
            if (!supply_low) begin
                qual_cnt_r <= 8'h00;
            end else if (qual_cnt_r != qual_len_r) begin
                qual_cnt_r <= qual_cnt_r + 8'h01;
            end
        end
    end

    // RL24 qualified event
    assign bor_event = supply_low && (qual_cnt_r == qual_len_r);

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cause_nxt = cause_r;
        unique case (state_r)
            BRST_S_POR:  state_nxt = BRST_S_HOLD;
            BRST_S_HOLD: begin
                // RL4 wait for good supply
                if (!supply_low) begin
                    // RL5 RL8 delay or skip
                    if (powerup_timer_on) begin
                        state_nxt = BRST_S_POWERUP_TIMER;
                    end else if (crystal) begin
                        state_nxt = BRST_S_OST;
                    end else begin
                        state_nxt = BRST_S_MCLRW;
                    end
                end
            end
            BRST_S_POWERUP_TIMER: begin
                // RL7 delay then start-up count
                if (powerup_timer_done) begin
                    state_nxt = crystal ? BRST_S_OST : BRST_S_MCLRW;
                end
            end
            BRST_S_OST: begin
                if (ost_done) begin
                    state_nxt = BRST_S_MCLRW;
                end
            end
            BRST_S_MCLRW: begin
                // RL9 release as soon as pin high
                if (MASTER_CLEAR_N && !supply_low) begin
                    state_nxt = BRST_S_RUN;
                end
            end
            BRST_S_RUN: begin
                if (!MASTER_CLEAR_N) begin
                    state_nxt = BRST_S_MCLRW;
                    cause_nxt = BRST_C_MRUN;
                end else if (WATCHDOG_TIMEOUT) begin
                    state_nxt = BRST_S_MCLRW;
                    cause_nxt = BRST_C_WDT;
                end else if (SLEEP_ENTER) begin
                    state_nxt = BRST_S_SLEEP;
                end
            end
            BRST_S_SLEEP: begin
                // RL21 start-up count on wake in crystal modes
                if (!MASTER_CLEAR_N) begin
                    state_nxt = BRST_S_MCLRW;
                    cause_nxt = BRST_C_MSLP;
                end else if (WATCHDOG_TIMEOUT) begin
                    state_nxt = crystal ? BRST_S_WAKE : BRST_S_RUN;
                    cause_nxt = BRST_C_WWAKE;
                end else if (IRQ_WAKE) begin
                    state_nxt = crystal ? BRST_S_WAKE : BRST_S_RUN;
                    cause_nxt = BRST_C_IWAKE;
                end
            end
            BRST_S_WAKE: begin
                if (ost_done) begin
                    state_nxt = BRST_S_RUN;
                end
            end
        endcase
        // RL6 dip anywhere re-enters brown-out hold
        if (bor_event && state_r != BRST_S_POR && state_r != BRST_S_HOLD) begin
            state_nxt = BRST_S_HOLD;
            cause_nxt = BRST_C_BOR;
        end
    end

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= BRST_S_POR;
            cause_r <= BRST_C_POR;
        end else if (CE) begin
            state_r <= state_nxt;
            cause_r <= cause_nxt;
        end
    end

    // ------------------------------------------------------------
    // power-up and start-up counters
    // ------------------------------------------------------------
    // RL6 counter cleared outside delay state
    always_ff @(posedge CLK) begin
        if (RST) begin
            powerup_timer_cnt_r <= 23'h000000;
        end else if (CE) begin
            if (state_r == BRST_S_POWERUP_TIMER && state_nxt == BRST_S_POWERUP_TIMER) begin
                powerup_timer_cnt_r <= powerup_timer_cnt_r + 23'h000001;
            end else begin
                powerup_timer_cnt_r <= 23'h000000;
            end
        end
    end

    // RL20 count oscillator ticks
    always_ff @(posedge CLK) begin
        if (RST) begin
            ost_cnt_r <= 11'h000;
        end else if (CE) begin
            if (state_nxt != BRST_S_OST && state_nxt != BRST_S_WAKE) begin
                ost_cnt_r <= 11'h000;
            end else if (state_r == state_nxt && OSC_TICK && !ost_done) begin
                ost_cnt_r <= ost_cnt_r + 11'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // timeout and powerdown flags
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            // RL14 power-on sets both
            to_n_r <= 1'b1;
            pd_n_r <= 1'b1;
        end else if (CE && state_nxt != state_r) begin
            // RL15 flag codes per event
            if (state_nxt == BRST_S_HOLD) begin
                to_n_r <= 1'b1;
                pd_n_r <= 1'b1;
            end else if (state_nxt == BRST_S_SLEEP) begin
                to_n_r <= 1'b1;
                pd_n_r <= 1'b0;
            end else if (cause_nxt == BRST_C_WDT) begin
                to_n_r <= 1'b0;
                pd_n_r <= 1'b1;
            end else if (cause_nxt == BRST_C_WWAKE) begin
                to_n_r <= 1'b0;
                pd_n_r <= 1'b0;
            end else if (cause_nxt == BRST_C_MSLP || cause_nxt == BRST_C_IWAKE) begin
                to_n_r <= 1'b1;
                pd_n_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // power_reset_cause register
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            // RL10 RL11 bit 0 follows enable at power-on
            bor_bit_r <= CFG.brownout_enable;
            // RL12 bit 1 cleared by power-on only
            por_bit_r <= 1'b0;
        end else if (CE) begin
            // RL10 RL18 brown-out clears, beats software set
            if (bor_event && state_r != BRST_S_HOLD) begin
                bor_bit_r <= 1'b0;
            end else if (REG_WR && REG_ADDR == `BRST_OFS_CAUSE) begin
                bor_bit_r <= REG_WDATA[`BRST_CAUSE_BOR_BIT];
            end
            if (REG_WR && REG_ADDR == `BRST_OFS_CAUSE) begin
                por_bit_r <= REG_WDATA[`BRST_CAUSE_POR_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // qualification length register
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            qual_len_r <= `BRST_QUAL_RESET;
        end else if (CE && REG_WR && REG_ADDR == `BRST_OFS_QUAL) begin
            qual_len_r <= REG_WDATA;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
        end else if (CE) begin
            if (!REG_RD) begin
                REG_RDATA <= 8'h00;
            end else begin
                unique case (REG_ADDR)
                    `BRST_OFS_CAUSE: REG_RDATA <= {6'h00, por_bit_r, bor_bit_r};
                    `BRST_OFS_STATE: REG_RDATA <= {to_n_r, pd_n_r, cause_r, state_r};
                    `BRST_OFS_QUAL:  REG_RDATA <= qual_len_r;
                    default:         REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // core control outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            CORE_RESET       <= 1'b1;
            CORE_RUN         <= 1'b0;
            TIMEOUT_FLAG_N   <= 1'b1;
            POWERDOWN_FLAG_N <= 1'b1;
        end else if (CE) begin
            // RL4 RL7 reset held until sequence ends
            CORE_RESET       <= !(state_nxt inside {BRST_S_RUN, BRST_S_SLEEP, BRST_S_WAKE});
            CORE_RUN         <= (state_nxt == BRST_S_RUN);
            TIMEOUT_FLAG_N   <= to_n_r;
            POWERDOWN_FLAG_N <= pd_n_r;
        end
    end

    // wake source latched for the vector choice
    always_ff @(posedge CLK) begin
        if (RST) begin
            wake_irq_r <= 1'b0;
        end else if (CE && state_r == BRST_S_SLEEP) begin
            wake_irq_r <= IRQ_WAKE && GLOBAL_IRQ_ENABLE;
        end
    end

    // ------------------------------------------------------------
    // core load on release
    // ------------------------------------------------------------
    // RL17 status per reset kind
    always_comb begin
        unique case (cause_r)
            BRST_C_POR, BRST_C_BOR: st_load = {`BRST_ST_POR_MASK, `BRST_ST_POR_VAL};
            BRST_C_MRUN:  st_load = {`BRST_ST_MRUN_MASK, `BRST_ST_MRUN_VAL};
            BRST_C_MSLP:  st_load = {`BRST_ST_MSLP_MASK, `BRST_ST_MSLP_VAL};
            BRST_C_WDT:   st_load = {`BRST_ST_WDT_MASK, `BRST_ST_WDT_VAL};
            BRST_C_WWAKE: st_load = {`BRST_ST_WWAKE_MASK, `BRST_ST_WWAKE_VAL};
            BRST_C_IWAKE: st_load = {`BRST_ST_IWAKE_MASK, `BRST_ST_IWAKE_VAL};
            default:      st_load = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            CORE_LOAD <= '0;
        end else if (CE) begin
            CORE_LOAD            <= '0;
            CORE_LOAD.init_value <= `BRST_INIT_VALUE;
            if (state_nxt == BRST_S_RUN && state_r != BRST_S_RUN) begin
                CORE_LOAD.load <= 1'b1;
                // RL16 reset vector by default
                CORE_LOAD.pc   <= `BRST_PC_RESET;
                {CORE_LOAD.status_mask, CORE_LOAD.status_value} <= st_load;
                if (cause_r == BRST_C_WWAKE || cause_r == BRST_C_IWAKE) begin
                    // RL16 RL19 wake continues, registers kept
                    CORE_LOAD.pc <= (cause_r == BRST_C_IWAKE && wake_irq_r) ?
                                    `BRST_PC_IRQ_VEC : PC_NOW + 13'h0001;
                end else begin
                    // RL19 reset loads initial values
                    CORE_LOAD.reg_init <= 1'b1;
                end
            end
        end
    end

endmodule : brst_seq
`default_nettype wire

// file: tb/brst_far.sv
// Purpose: supply monitors and oscillator
// Assumes: VDD in tenths of a volt
// Notes:   one tick every second clock
`timescale 1ns/100ps
`default_nettype none
module brst_far (
    // clock, supply, monitors
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [7:0] VDD,
    output var  logic       LOW_4V0,
    output var  logic       LOW_2V5,
    output var  logic       TICK
);
    // ----------------------------------------
    // comparators and oscillator
    // ----------------------------------------
    assign LOW_4V0 = VDD < 8'h28;
    assign LOW_2V5 = VDD < 8'h19;
    always_ff @(posedge CLK) begin
        TICK <= !RST && !TICK;
    end
endmodule : brst_far
`default_nettype wire

// file: tb/brst_seq_assertions.sv
// Purpose: port checks for brst_seq
// Assumes: CE held high
// Notes:   bind at the foot
`timescale 1ns/100ps
`default_nettype none
module brst_chk
    import brst_pkg::*;
(
    // inputs and outputs watched
    input wire logic CLK,
    input wire logic RST,
    input wire brst_pkg::brst_cfg_t CFG,
    input wire logic MASTER_CLEAR_N,
    input wire logic WATCHDOG_TIMEOUT,
    input wire logic SLEEP_ENTER,
    input wire logic CORE_RESET,
    input wire logic CORE_RUN,
    input wire logic TIMEOUT_FLAG_N,
    input wire logic POWERDOWN_FLAG_N,
    input wire brst_pkg::brst_core_load_t CORE_LOAD
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    AST_POR_HOLD: assert property ($fell(RST) |-> CORE_RESET [*2])
        else $error("early release");
    AST_POR_FLAGS: assert property ($fell(RST) |-> TIMEOUT_FLAG_N && POWERDOWN_FLAG_N)
        else $error("power-on flags");
    AST_LOAD_ONCE: assert property ($rose(CORE_RUN) |-> CORE_LOAD.load ##1 !CORE_LOAD.load)
        else $error("load pulse");
    AST_RESET_PC: assert property (CORE_LOAD.reg_init |-> CORE_LOAD.pc == 13'h0000)
        else $error("reset pc");
    AST_INIT_VAL: assert property (CORE_LOAD.load |-> CORE_LOAD.init_value == 8'hff)
        else $error("init value");
    AST_NO_BOR: assert property (CORE_RUN && !CFG.brownout_enable && MASTER_CLEAR_N
        && !WATCHDOG_TIMEOUT && !SLEEP_ENTER |=> CORE_RUN) else $error("stray reset");
    AST_WDT_FLAGS: assert property (CORE_RUN && WATCHDOG_TIMEOUT && MASTER_CLEAR_N
        && !CFG.brownout_enable |-> ##2 !TIMEOUT_FLAG_N && POWERDOWN_FLAG_N) else $error("wdt flags");
    AST_RC_FAST: assert property ($fell(RST) && CFG.osc_select == BRST_OSC_RC
        && CFG.powerup_timer_enable_n && !CFG.brownout_enable && MASTER_CLEAR_N
        |-> ##[1:8] CORE_RUN) else $error("rc time-out");
endmodule : brst_chk
bind brst_seq brst_chk chk_u (.CLK(CLK), .RST(RST), .CFG(CFG), .MASTER_CLEAR_N(MASTER_CLEAR_N),
    .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .SLEEP_ENTER(SLEEP_ENTER), .CORE_RESET(CORE_RESET),
    .CORE_RUN(CORE_RUN), .TIMEOUT_FLAG_N(TIMEOUT_FLAG_N), .POWERDOWN_FLAG_N(POWERDOWN_FLAG_N),
    .CORE_LOAD(CORE_LOAD));
`default_nettype wire

// file: tb/brst_seq_tb.sv
// Purpose: self-checking bench for brst_seq
// Assumes: power-up delay cut to 20 cycles
// Notes:   expected reads and loads queue up
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module brst_seq_tb;
    import brst_pkg::*;
    // ----------------------------------------
    // design, far side, monitor
    // ----------------------------------------
    localparam int PW = 20;
    logic CLK = 1'h0, RST = 1'h1, rd = 1'h0, wr = 1'h0, mc_n = 1'h1, wdt = 1'h0, slp = 1'h0;
    logic irq = 1'h0, global_irq_enable = 1'h0, lo4, lo2, tick, crst, crun, to_n, pd_n, rd_p = 1'h0;
    logic [1:0] adr = 2'h0;
    logic [7:0] wd = 8'h00, vdd = 8'h32, rdat, e8, rq[$];
    logic [12:0] pc = 13'h0000, p;
    logic [28:0] e29, lq[$];
    brst_cfg_t cfg = '0;
    brst_core_load_t ld;
    int err_count = 0, n_compared = 0, n;
    always #5 CLK = !CLK;
    brst_far far_u (.CLK(CLK), .RST(RST), .VDD(vdd), .LOW_4V0(lo4), .LOW_2V5(lo2), .TICK(tick));
    brst_seq #(.POWERUP_TIMER_CYCLES(PW)) dut_u (.CLK(CLK), .RST(RST), .CE(1'h1), .CFG(cfg),
        .SUPPLY_LOW_4V0(lo4), .SUPPLY_LOW_2V5(lo2), .OSC_TICK(tick), .MASTER_CLEAR_N(mc_n),
        .WATCHDOG_TIMEOUT(wdt), .SLEEP_ENTER(slp), .IRQ_WAKE(irq), .GLOBAL_IRQ_ENABLE(global_irq_enable),
        .PC_NOW(pc), .REG_ADDR(adr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
        .CORE_RESET(crst), .CORE_RUN(crun), .TIMEOUT_FLAG_N(to_n), .POWERDOWN_FLAG_N(pd_n),
        .CORE_LOAD(ld));
    always @(posedge CLK) begin
        if (rd_p) begin
            e8 = rq.pop_front();
            `CHK("rdata", e8, rdat)
        end
        if (ld.load === 1'h1) begin
            e29 = lq.pop_front();
            `CHK("load", e29, {ld.pc, ld.status_mask, ld.status_value})
        end
        rd_p <= rd;
    end
    task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge CLK);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        if (!w) rq.push_back(d);
        @(posedge CLK);
        wr <= 1'h0;
        rd <= 1'h0;
    endtask : acc
    task automatic wait_run(input int lim);
        for (n = 0; crun !== 1'h1 && n < lim; n++) @(posedge CLK);
        `CHK("run", 1'h1, crun)
    endtask : wait_run
    task automatic pwrup(input brst_cfg_t c);
        cfg <= c;
        RST <= 1'h1;
        repeat (5) @(posedge CLK);
        RST <= 1'h0;
    endtask : pwrup
    task automatic dip(input logic [7:0] v, input int k);
        vdd <= v;
        repeat (k) @(posedge CLK);
    endtask : dip
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    initial begin
        #400us;
        err_count++;
        test_done();
    end
    initial begin
        n = $urandom(32'h157f);
        lq.push_back({13'h0000, 8'hf8, 8'h18});
        pwrup(5'h19);
        wait_run(3000);
        `CHK("powerup_timer_ost", 1'h1, n inside {[PW + 2048:PW + 2060]})
        acc(1'h0, 2'h0, 8'h01);
        acc(1'h0, 2'h2, 8'h10);
        p = 13'($urandom);
        acc(1'h1, 2'h0, p[7:0]);
        acc(1'h0, 2'h0, {6'h00, p[1:0]});
        acc(1'h1, 2'h3, 8'hff);
        acc(1'h0, 2'h3, 8'h00);
        acc(1'h1, 2'h0, 8'h03);
        $display("test power-up done");
        cfg.brownout_level_select <= 1'h0;
        dip(8'h1e, 40);
        `CHK("level", 1'h1, crun)
        cfg.brownout_level_select <= 1'h1;
        dip(8'h32, 1);
        dip(8'h1e, 5);
        dip(8'h32, 30);
        `CHK("short dip", 1'h1, crun)
        dip(8'h1e, 40);
        `CHK("bor", 1'h1, crst)
        dip(8'h32, 12);
        dip(8'h1e, 30);
        lq.push_back({13'h0000, 8'hf8, 8'h18});
        vdd <= 8'h32;
        wait_run(3000);
        `CHK("restart", 1'h1, n inside {[PW + 2048:PW + 2060]})
        acc(1'h0, 2'h0, 8'h02);
        `CHK("bor flags", 2'h3, {to_n, pd_n})
        $display("test brown-out done");
        cfg.brownout_enable <= 1'h0;
        lq.push_back({13'h0000, 8'hf8, 8'h08});
        @(posedge CLK);
        wdt <= 1'h1;
        @(posedge CLK);
        wdt <= 1'h0;
        @(posedge CLK);
        wait_run(20);
        `CHK("no ost", 1'h1, n < 10)
        lq.push_back({13'h0000, 8'he0, 8'h00});
        mc_n <= 1'h0;
        repeat (4) @(posedge CLK);
        mc_n <= 1'h1;
        wait_run(10);
        `CHK("master_clear_n flags", 2'h1, {to_n, pd_n})
        $display("test resets done");
        for (int i = 0; i < 3; i++) begin
            p = 13'($urandom);
            pc <= p;
            global_irq_enable <= i == 0;
            lq.push_back({i == 0 ? 13'h0004 : p + 13'h0001, 8'h18, i == 1 ? 8'h00 : 8'h10});
            slp <= 1'h1;
            @(posedge CLK);
            slp <= 1'h0;
            @(posedge CLK);
            irq <= i != 1;
            wdt <= i == 1;
            @(posedge CLK);
            irq <= 1'h0;
            wdt <= 1'h0;
            wait_run(2200);
            `CHK("wake flags", {i != 1, 1'h0}, {to_n, pd_n})
        end
        $display("test wake done");
        lq.push_back({13'h0000, 8'hf8, 8'h18});
        pwrup(5'h07);
        wait_run(10);
        acc(1'h0, 2'h0, 8'h00);
        $display("test rc done");
        test_done();
    end
endmodule : brst_seq_tb
`default_nettype wire
